// file: design/sensor_misc_config_defines.svh
// register offsets, field positions, reset values and timing counts for the misc config bank
`ifndef SENSOR_MISC_CONFIG_DEFINES_SVH
`define SENSOR_MISC_CONFIG_DEFINES_SVH
`define OFS_NVM_PERMIT 8'h6A
`define OFS_WIRING 8'h6B
`define OFS_GYRO_TRIG 8'h6C
`define OFS_SELF_CHECK 8'h6D
`define OFS_PERSIST 8'h70
`define RST_NVM_PERMIT 8'h00
`define RST_WIRING 8'h00
`define RST_GYRO_TRIG 8'h00
`define RST_SELF_CHECK 8'h00
`define MASK_NVM_PERMIT 8'h02
`define MASK_WIRING 8'h01
`define MASK_GYRO_TRIG 8'h7F
`define MASK_SELF_CHECK 8'h1F
`define MASK_PERSIST 8'h07
`define BIT_NVM_PROG 1
`define BIT_THREE_WIRE 0
`define BIT_WAKE_INT 6
`define BIT_SLEEP_STATE 5
`define BIT_WAKE_HI 4
`define BIT_WAKE_LO 3
`define BIT_SLEEP_HI 2
`define BIT_SLEEP_LO 0
`define BIT_GYRO_ST 4
`define BIT_ACC_AMP 3
`define BIT_ACC_SIGN 2
`define BIT_ACC_EN_HI 1
`define BIT_ACC_EN_LO 0
`define BIT_WDT_EN 2
`define BIT_WDT_SEL 1
`define BIT_SPI_ONLY 0
`define WDT_SHORT_MS 1
`define WDT_LONG_MS 50
`define CLK_MHZ 250
`define WDT_SHORT_CYC (`WDT_SHORT_MS * 1000 * `CLK_MHZ)
`define WDT_LONG_CYC (`WDT_LONG_MS * 1000 * `CLK_MHZ)
`endif

// file: design/sensor_misc_config_pkg.sv
// types shared by the misc config bank
package sensor_misc_config_pkg;
	// gyro power modes as reported in the power status field
	typedef enum logic [1:0] {
		GYRO_SUSPEND = 2'h0,
		GYRO_NORMAL = 2'h1,
		GYRO_FAST_START = 2'h3
	} gyroMode_t;
	// register access request from the serial front end
	typedef struct packed {
		logic wrStb;
		logic rdStb;
		logic [7:0] addr;
		logic [7:0] wdata;
	} regReq_t;
	// detector and pin events feeding the power triggers
	typedef struct packed {
		logic anyMotion;
		logic noMotion;
		logic pinOneActive;
		logic pinTwoActive;
	} trigIn_t;
	// watchdog states, one-hot
	typedef enum logic [1:0] {
		WD_IDLE = 2'b01,
		WD_COUNT = 2'b10
	} wdState_t;
endpackage

// file: design/sensor_misc_config_regs.sv
// misc configuration registers: nvm permit, wiring, gyro power triggers, self check, persistent settings
//
// Operation
// [RQ1] bit 1 permits non-volatile programming
// [RQ2] bit 0 selects three-wire serial
// [RQ3] wake needs all enabled wake conditions
// [RQ4] any enabled sleep condition sends sleep
// [RQ5] wake wins over simultaneous sleep
// [RQ6] pin events follow edge/level setting
// [RQ7] sleep state picks suspend or fast-start
// [RQ8] wake interrupt pulse when enabled
// [RQ9] each transition updates gyro power mode
// [RQ10] bit 4 starts gyro self check
// [RQ11] amplitude bit high deflection, default low
// [RQ12] sign bit positive when one
// [RQ13] field 01 starts accel self check
// [RQ14] host waits 50 ms for results
// [RQ15] host sets accel config beforehand
// [RQ16] accel self check acts on all axes
// [RQ17] persistent settings load from nvm at boot
// [RQ18] watchdog enable on serial data line
// [RQ19] watchdog period 1 ms or 50 ms
// [RQ20] spi-only in automatic interface mode
// [RQ21] host writes zero to reserved bits
// [RQ22] watchdog timeout idles the i2c slave
`timescale 1ns/100ps
`default_nettype none
`include "sensor_misc_config_defines.svh"
module sensor_misc_config_regs
	import sensor_misc_config_pkg::*;
#(
	parameter int unsigned WDT_SHORT = `WDT_SHORT_CYC,
	parameter int unsigned WDT_LONG = `WDT_LONG_CYC
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// register access
	input wire regReq_t regReq,
	output logic [7:0] rdData,
	// boot load of persistent settings
	input wire logic nvmLoad,
	input wire logic [7:0] nvmData,
	// trigger events, already shaped by the pin edge/level setting
	input wire trigIn_t trigIn,
	// interface state
	input wire logic autoConfigMode,
	input wire logic i2cMode,
	input wire logic dataLineHeld,
	// control outputs
	output logic nvmProgEnable,
	output logic threeWireSerialSelect,
	output logic spiOnly,
	output logic i2cWatchdogExpire,
	output logic wakeIrq,
	output logic [1:0] gyroPowerMode,
	output logic gyroSelfTestStart,
	output logic accelSelfTestOn,
	output logic accelSelfTestAmpHigh,
	output logic accelSelfTestPositive
);
	localparam int unsigned CW = 24;
	logic [7:0] permit_r, permit_nxt, wiring_r, wiring_nxt, trig_r, trig_nxt;
	logic [7:0] check_r, check_nxt, persist_r, persist_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic wake_r, wake_nxt, gst_r, gst_nxt, exp_r, exp_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	wdState_t wd_r, wd_nxt;
	logic wakeCond, sleepCond, wakeEn, sleepEn;
	logic [CW-1:0] limit;

	function automatic logic hit(input regReq_t r, input logic [7:0] ofs);
		hit = r.wrStb && (r.addr == ofs);
	endfunction

	// gyro trigger evaluation; pin events arrive pre-shaped by interrupt output control
	always_comb begin
		wakeEn = trig_r[`BIT_WAKE_HI] | trig_r[`BIT_WAKE_LO];
		wakeCond = wakeEn && (!trig_r[`BIT_WAKE_HI] || trigIn.anyMotion) // RQ3
			&& (!trig_r[`BIT_WAKE_LO] || trigIn.pinOneActive); // RQ6
		sleepEn = |trig_r[`BIT_SLEEP_HI:`BIT_SLEEP_LO];
		sleepCond = (trig_r[2] && trigIn.noMotion) || (trig_r[1] && !trigIn.pinOneActive)
			|| (trig_r[0] && trigIn.pinTwoActive); // RQ4
	end

	// register writes, masked so reserved bits stay zero
	always_comb begin
		permit_nxt = hit(regReq, `OFS_NVM_PERMIT) ? (regReq.wdata & `MASK_NVM_PERMIT) : permit_r; // RQ1
		wiring_nxt = hit(regReq, `OFS_WIRING) ? (regReq.wdata & `MASK_WIRING) : wiring_r; // RQ2
		trig_nxt = hit(regReq, `OFS_GYRO_TRIG) ? (regReq.wdata & `MASK_GYRO_TRIG) : trig_r;
		check_nxt = hit(regReq, `OFS_SELF_CHECK) ? (regReq.wdata & `MASK_SELF_CHECK) : check_r;
		persist_nxt = persist_r;
		if (nvmLoad) begin
			persist_nxt = nvmData & `MASK_PERSIST; // RQ17
		end else if (hit(regReq, `OFS_PERSIST)) begin
			persist_nxt = regReq.wdata & `MASK_PERSIST;
		end
		// start pulse for gyro self check only on a written one
		gst_nxt = hit(regReq, `OFS_SELF_CHECK) && regReq.wdata[`BIT_GYRO_ST]; // RQ10
	end

	// gyro power state; wake checked first so it wins
	always_comb begin
		mode_nxt = mode_r;
		wake_nxt = 1'b0;
		if (wakeCond && mode_r != GYRO_NORMAL) begin
			mode_nxt = GYRO_NORMAL; // RQ5 RQ9
			wake_nxt = trig_r[`BIT_WAKE_INT]; // RQ8
		end else if (!wakeCond && sleepEn && sleepCond && mode_r == GYRO_NORMAL) begin
			mode_nxt = trig_r[`BIT_SLEEP_STATE] ? GYRO_SUSPEND : GYRO_FAST_START; // RQ7 RQ9
		end
	end

	// i2c watchdog on the serial data input pin
	always_comb begin
		limit = persist_r[`BIT_WDT_SEL] ? CW'(WDT_LONG) : CW'(WDT_SHORT); // RQ19
		wd_nxt = wd_r;
		cnt_nxt = cnt_r;
		exp_nxt = 1'b0;
		case (wd_r)
			WD_IDLE: begin
				cnt_nxt = '0;
				if (persist_r[`BIT_WDT_EN] && i2cMode && dataLineHeld) begin
					wd_nxt = WD_COUNT; // RQ18
				end
			end
			WD_COUNT: begin
				if (!dataLineHeld || !persist_r[`BIT_WDT_EN] || !i2cMode) begin
					wd_nxt = WD_IDLE;
				end else if (cnt_r >= limit - CW'(1)) begin
					exp_nxt = 1'b1; // RQ22
					wd_nxt = WD_IDLE;
				end else begin
					cnt_nxt = cnt_r + CW'(1);
				end
			end
			default: wd_nxt = WD_IDLE;
		endcase
	end

	// state registers; clkEn freezes everything
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			permit_r <= `RST_NVM_PERMIT;
			wiring_r <= `RST_WIRING;
			trig_r <= `RST_GYRO_TRIG;
			check_r <= `RST_SELF_CHECK;
			persist_r <= 8'h00;
			mode_r <= GYRO_SUSPEND;
			wake_r <= 1'b0;
			gst_r <= 1'b0;
			exp_r <= 1'b0;
			cnt_r <= '0;
			wd_r <= WD_IDLE;
		end else if (clkEn) begin
			permit_r <= permit_nxt;
			wiring_r <= wiring_nxt;
			trig_r <= trig_nxt;
			check_r <= check_nxt;
			persist_r <= persist_nxt;
			mode_r <= mode_nxt;
			wake_r <= wake_nxt;
			gst_r <= gst_nxt;
			exp_r <= exp_nxt;
			cnt_r <= cnt_nxt;
			wd_r <= wd_nxt;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (regReq.addr)
			`OFS_NVM_PERMIT: rdData = permit_r;
			`OFS_WIRING: rdData = wiring_r;
			`OFS_GYRO_TRIG: rdData = trig_r;
			`OFS_SELF_CHECK: rdData = check_r;
			`OFS_PERSIST: rdData = persist_r;
			default: rdData = 8'h00;
		endcase
	end

	// outputs from flip-flops; spiOnly is also gated by the autoConfigMode input
	assign nvmProgEnable = permit_r[`BIT_NVM_PROG]; // RQ1
	assign threeWireSerialSelect = wiring_r[`BIT_THREE_WIRE]; // RQ2
	assign spiOnly = autoConfigMode & persist_r[`BIT_SPI_ONLY]; // RQ20
	assign i2cWatchdogExpire = exp_r;
	assign wakeIrq = wake_r;
	assign gyroPowerMode = mode_r;
	assign gyroSelfTestStart = gst_r;
	// one enable drives all three axes; only code 01 runs the test
	assign accelSelfTestOn = (check_r[`BIT_ACC_EN_HI:`BIT_ACC_EN_LO] == 2'h1); // RQ13 RQ16
	assign accelSelfTestAmpHigh = check_r[`BIT_ACC_AMP]; // RQ11
	assign accelSelfTestPositive = check_r[`BIT_ACC_SIGN]; // RQ12

	// checks
	AST_PERMIT: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ1
		clkEn && hit(regReq, `OFS_NVM_PERMIT) |=> nvmProgEnable == $past(regReq.wdata[1]))
		else $error("nvm permit not taken");
	AST_WIRING: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ2
		clkEn && hit(regReq, `OFS_WIRING) |=> threeWireSerialSelect == $past(regReq.wdata[0]))
		else $error("wiring select not taken");
	AST_WAKE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ3
		clkEn && wakeCond && gyroPowerMode != GYRO_NORMAL |=> gyroPowerMode == GYRO_NORMAL)
		else $error("wake not taken");
	AST_SLEEP: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ4
		clkEn && !wakeCond && sleepCond && gyroPowerMode == GYRO_NORMAL |=> gyroPowerMode != GYRO_NORMAL)
		else $error("sleep not taken");
	AST_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ5
		clkEn && wakeCond && sleepCond |=> gyroPowerMode == GYRO_NORMAL)
		else $error("sleep beat wake");
	AST_TARGET: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ7
		$changed(gyroPowerMode) && gyroPowerMode != GYRO_NORMAL
		|-> gyroPowerMode == ($past(trig_r[5]) ? GYRO_SUSPEND : GYRO_FAST_START))
		else $error("wrong sleep target");
	AST_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ8
		wakeIrq |-> $past(trig_r[6]) && gyroPowerMode == GYRO_NORMAL)
		else $error("spurious wake irq");
	AST_ACC: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ13
		accelSelfTestOn |-> check_r[1:0] == 2'h1)
		else $error("accel self check code wrong");
	AST_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ17
		clkEn && nvmLoad |=> persist_r == ($past(nvmData) & 8'h07))
		else $error("nvm load missed");
	AST_SPI: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ20
		spiOnly |-> autoConfigMode && persist_r[0])
		else $error("spi only wrong");
	AST_SPI_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ20
		!autoConfigMode |-> !spiOnly)
		else $error("spi only outside auto mode");
	// register bits move only on a write to their own offset
	AST_PERMIT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ1
		clkEn && !hit(regReq, `OFS_NVM_PERMIT) |=> $stable(nvmProgEnable))
		else $error("nvm permit moved without write");
	AST_WIRING_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ2
		clkEn && !hit(regReq, `OFS_WIRING) |=> $stable(threeWireSerialSelect))
		else $error("wiring moved without write");
	// each enabled wake condition is needed on its own
	AST_WAKE_ANY: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ3
		clkEn && trig_r[4] && !trigIn.anyMotion && gyroPowerMode != GYRO_NORMAL |=> $stable(gyroPowerMode))
		else $error("wake without any-motion");
	AST_WAKE_PIN: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ3
		clkEn && trig_r[3] && !trigIn.pinOneActive && gyroPowerMode != GYRO_NORMAL |=> $stable(gyroPowerMode))
		else $error("wake without pin one");
	AST_NO_WAKE_EN: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ3
		clkEn && trig_r[4:3] == 2'h0 && gyroPowerMode != GYRO_NORMAL |=> $stable(gyroPowerMode))
		else $error("wake with no wake trigger");
	AST_SLEEP_NONE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ4
		clkEn && trig_r[2:0] == 3'h0 && gyroPowerMode == GYRO_NORMAL |=> gyroPowerMode == GYRO_NORMAL)
		else $error("sleep with no sleep trigger");
	AST_SLEEP_PIN2: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ4
		clkEn && trig_r[0] && trigIn.pinTwoActive && !wakeCond && gyroPowerMode == GYRO_NORMAL
		|=> gyroPowerMode != GYRO_NORMAL)
		else $error("pin two sleep missed");
	// wake interrupt follows the enable bit and lasts one cycle
	AST_IRQ_ON: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ8
		clkEn && wakeCond && gyroPowerMode != GYRO_NORMAL && trig_r[6] |=> wakeIrq)
		else $error("wake irq missing");
	AST_IRQ_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ8
		clkEn && !trig_r[6] |=> !wakeIrq)
		else $error("wake irq while disabled");
	AST_IRQ_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ8
		clkEn && wakeIrq |=> !wakeIrq)
		else $error("wake irq too long");
	AST_MODE_LEGAL: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ9
		gyroPowerMode != 2'h2)
		else $error("illegal gyro mode");
	AST_GST_ON: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ10
		clkEn && hit(regReq, `OFS_SELF_CHECK) && regReq.wdata[4] |=> gyroSelfTestStart)
		else $error("gyro self check not started");
	AST_GST_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ10
		clkEn && gyroSelfTestStart && !hit(regReq, `OFS_SELF_CHECK) |=> !gyroSelfTestStart)
		else $error("gyro self check start too long");
	AST_AMP: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ11
		clkEn && hit(regReq, `OFS_SELF_CHECK) |=> accelSelfTestAmpHigh == $past(regReq.wdata[3]))
		else $error("amplitude bit not taken");
	AST_SIGN: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ12
		clkEn && hit(regReq, `OFS_SELF_CHECK) |=> accelSelfTestPositive == $past(regReq.wdata[2]))
		else $error("sign bit not taken");
	AST_ACC_ON: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ13
		clkEn && hit(regReq, `OFS_SELF_CHECK) |=> accelSelfTestOn == ($past(regReq.wdata[1:0]) == 2'h1))
		else $error("accel self check enable not taken");
	AST_PERSIST_WR: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ18
		clkEn && !nvmLoad && hit(regReq, `OFS_PERSIST) |=> persist_r == ($past(regReq.wdata) & 8'h07))
		else $error("persistent write not taken");
	// watchdog only fires while enabled, in i2c mode and with the line held
	AST_WDT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ18
		clkEn && !persist_r[2] |=> !i2cWatchdogExpire)
		else $error("watchdog fired while disabled");
	AST_WDT_I2C: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ18
		clkEn && !i2cMode |=> !i2cWatchdogExpire)
		else $error("watchdog fired outside i2c");
	AST_WDT_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ22
		clkEn && !dataLineHeld |=> !i2cWatchdogExpire)
		else $error("watchdog fired on free line");
	AST_WDT_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ22
		clkEn && i2cWatchdogExpire |=> !i2cWatchdogExpire)
		else $error("watchdog expiry too long");
	AST_WDT_ST: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ18
		wd_r == WD_IDLE || wd_r == WD_COUNT)
		else $error("watchdog state not one-hot");
	AST_WDT_ENTER: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ18
		clkEn && wd_r == WD_IDLE && persist_r[2] && i2cMode && dataLineHeld |=> wd_r == WD_COUNT)
		else $error("watchdog did not start");
	COV_WAKE: cover property (@(posedge ref_clk) disable iff (!rst_n) wakeIrq);
	COV_SLEEP: cover property (@(posedge ref_clk) disable iff (!rst_n) gyroPowerMode == GYRO_FAST_START);
	COV_WDT: cover property (@(posedge ref_clk) disable iff (!rst_n) i2cWatchdogExpire);
	COV_GST: cover property (@(posedge ref_clk) disable iff (!rst_n) gyroSelfTestStart);
	COV_SUSPEND: cover property (@(posedge ref_clk) disable iff (!rst_n)
		gyroPowerMode == GYRO_SUSPEND && $past(gyroPowerMode) == GYRO_NORMAL);
endmodule // sensor_misc_config_regs
`default_nettype wire

// file: verification/host_model.sv
// host processor model: single-byte register writes and reads
`timescale 1ns/100ps
`default_nettype none
module host_model
	import sensor_misc_config_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// register access toward the device
	input wire logic [7:0] rdData,
	output var regReq_t regReq
);
	initial regReq = '0;
	// write held for exactly one edge, then strobe dropped
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regReq <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk);
		regReq <= '{1'b0, 1'b0, a, 8'h00};
		#1;
	endtask
	// read data is combinational on the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regReq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk);
		#1 d = rdData;
	endtask
endmodule // host_model
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the misc config register bank
`timescale 1ns/100ps
`default_nettype none
`include "sensor_misc_config_defines.svh"
module testbench;
	import sensor_misc_config_pkg::*;
	localparam int unsigned WS = 8;
	localparam int unsigned WL = 20;
	logic ref_clk, rst_n, clkEn, nvmLoad, autoConfigMode, i2cMode, dataLineHeld;
	logic [7:0] nvmData, rdData, rv, got;
	trigIn_t trigIn;
	regReq_t regReq;
	logic nvmProgEnable, threeWireSerialSelect, spiOnly, i2cWatchdogExpire, wakeIrq;
	logic gyroSelfTestStart, accelSelfTestOn, accelSelfTestAmpHigh, accelSelfTestPositive;
	logic [1:0] gyroPowerMode, prevMode;
	logic [2:0] expQ[$];
	int fail_count, n_checks, stPulses, wdPulses, i;
	logic [7:0] offs [5] = '{`OFS_NVM_PERMIT, `OFS_WIRING, `OFS_GYRO_TRIG, `OFS_SELF_CHECK, `OFS_PERSIST};
	logic [7:0] masks [5] = '{`MASK_NVM_PERMIT, `MASK_WIRING, `MASK_GYRO_TRIG, `MASK_SELF_CHECK, `MASK_PERSIST};
	sensor_misc_config_regs #(.WDT_SHORT(WS), .WDT_LONG(WL)) sensor_misc_config_regs_inst (
		.ref_clk, .rst_n, .clkEn, .regReq, .rdData, .nvmLoad, .nvmData, .trigIn,
		.autoConfigMode, .i2cMode, .dataLineHeld, .nvmProgEnable, .threeWireSerialSelect,
		.spiOnly, .i2cWatchdogExpire, .wakeIrq, .gyroPowerMode, .gyroSelfTestStart,
		.accelSelfTestOn, .accelSelfTestAmpHigh, .accelSelfTestPositive);
	host_model host_model_inst (.ref_clk, .rdData, .regReq);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_mode(input logic [2:0] g, input logic [2:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: irq/mode %h expected %h", $time, g, e);
		end
	endtask
	// pin levels arrive already edge/level shaped, so the bench drives levels
	task automatic trig(input logic [3:0] t, input logic [2:0] e, input logic push);
		@(posedge ref_clk);
		trigIn <= t;
		if (push) expQ.push_back(e);
		repeat (4) @(posedge ref_clk);
	endtask
	// a bounded hold of the data line; a missing expiry shows as a wrong count
	task automatic wd(input int lim, input logic en);
		int n;
		n = 0;
		wdPulses = 0;
		@(posedge ref_clk);
		i2cMode <= 1'b1;
		dataLineHeld <= 1'b1;
		while (wdPulses == 0 && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
		dataLineHeld <= 1'b0;
		if (en) chk(8'(n >= lim && n <= lim + 3), 8'h01);
		else chk(8'(wdPulses), 8'h00);
	endtask
	task automatic close_out();
		if (expQ.size() != 0) fail_count++;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// monitor: each power-mode move or irq consumes the oldest expectation
	always @(posedge ref_clk) begin
		#1;
		if (rst_n && (gyroPowerMode !== prevMode || wakeIrq !== 1'b0)) chk_mode({wakeIrq, gyroPowerMode},
			(expQ.size() > 0) ? expQ.pop_front() : 3'h7);
		prevMode = gyroPowerMode;
		if (gyroSelfTestStart === 1'b1) stPulses++;
		if (i2cWatchdogExpire === 1'b1) wdPulses++;
	end
	// run cap so a hang still reaches the verdict
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
	initial begin
		rst_n = 1'b0; clkEn = 1'b1; nvmLoad = 1'b0; nvmData = 8'h00; autoConfigMode = 1'b0;
		i2cMode = 1'b0; dataLineHeld = 1'b0; trigIn = '0; prevMode = 2'h0;
		fail_count = 0; n_checks = 0; stPulses = 0; wdPulses = 0;
		rv = 8'($urandom(32'hD4F67FCD));
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		// reset values and an unmapped hole
		for (i = 0; i < 5; i++) begin
			host_model_inst.rd(offs[i], got);
			chk(got, 8'h00);
		end
		host_model_inst.wr(8'h6E, 8'hFF);
		host_model_inst.rd(8'h6E, got);
		chk(got, 8'h00);
		// random bytes read back through the reserved-bit masks
		for (i = 0; i < 15; i++) begin
			rv = 8'($urandom) & masks[i % 5];
			host_model_inst.wr(offs[i % 5], rv);
			host_model_inst.rd(offs[i % 5], got);
			chk(got, rv);
		end
		host_model_inst.wr(`OFS_NVM_PERMIT, 8'h02);
		chk(8'(nvmProgEnable), 8'h01);
		host_model_inst.wr(`OFS_WIRING, 8'h01);
		chk(8'(threeWireSerialSelect), 8'h01);
		host_model_inst.wr(`OFS_WIRING, 8'h00);
		chk(8'(threeWireSerialSelect), 8'h00);
		// frozen clock enable ignores the write
		@(posedge ref_clk) clkEn <= 1'b0;
		host_model_inst.wr(`OFS_NVM_PERMIT, 8'h00);
		@(posedge ref_clk) clkEn <= 1'b1;
		host_model_inst.rd(`OFS_NVM_PERMIT, got);
		chk(got, 8'h02);
		// boot load of persistent settings
		@(posedge ref_clk);
		nvmLoad <= 1'b1;
		nvmData <= 8'hFD;
		autoConfigMode <= 1'b1;
		@(posedge ref_clk) nvmLoad <= 1'b0;
		host_model_inst.rd(`OFS_PERSIST, got);
		chk(got, 8'h05);
		chk(8'(spiOnly), 8'h01);
		wd(WS, 1'b1);
		host_model_inst.wr(`OFS_PERSIST, 8'h06);
		wd(WL, 1'b1);
		host_model_inst.wr(`OFS_PERSIST, 8'h00);
		wd(0, 1'b0);
		chk(8'(spiOnly), 8'h00);
		// self check controls only; results settle far too slowly to read here
		host_model_inst.wr(8'h40, 8'h2C);
		stPulses = 0;
		host_model_inst.wr(`OFS_SELF_CHECK, 8'h1D);
		repeat (2) @(posedge ref_clk);
		#1 chk({stPulses[3:0], accelSelfTestOn, accelSelfTestAmpHigh, accelSelfTestPositive, 1'b0}, 8'h1E);
		host_model_inst.wr(`OFS_SELF_CHECK, 8'h02);
		repeat (2) @(posedge ref_clk);
		#1 chk({stPulses[3:0], accelSelfTestOn, accelSelfTestAmpHigh, accelSelfTestPositive, 1'b0}, 8'h10);
		// gyro power triggers: {anyMotion, noMotion, pinOne, pinTwo}
		host_model_inst.wr(`OFS_GYRO_TRIG, 8'h58);
		trig(4'b1000, 3'h0, 1'b0);
		trig(4'b1010, 3'h5, 1'b1);
		host_model_inst.wr(`OFS_GYRO_TRIG, 8'h3C);
		trig(4'b1110, 3'h0, 1'b0);
		trig(4'b0110, 3'h0, 1'b1);
		trig(4'b0000, 3'h0, 1'b0);
		host_model_inst.wr(`OFS_GYRO_TRIG, 8'h0A);
		trig(4'b0010, 3'h1, 1'b1);
		trig(4'b0000, 3'h3, 1'b1);
		host_model_inst.wr(`OFS_GYRO_TRIG, 8'h09);
		trig(4'b0010, 3'h1, 1'b1);
		trig(4'b0001, 3'h3, 1'b1);
		close_out();
	end
endmodule // testbench
`default_nettype wire
